// ---- pkg/pdc_params.svh ----
// constants for the port pin drive and pull-up controller
// assumes AXI4-Lite byte addresses of 12 bits and 32-bit data
`ifndef PDC_PARAMS_SVH
`define PDC_PARAMS_SVH
// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define PDC_ADDR_CTRL 12'h00C
`define PDC_ADDR_DDIR 12'h040
`define PDC_ADDR_RDIR 12'h044
`define PDC_ADDR_FSEL 12'h048
`define PDC_ADDR_CMD 12'h04C
`define PDC_ADDR_ACC 12'h050
// ---------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------
`define PDC_CTRL_PU_BIT 3
`define PDC_CTRL_SOD_BIT 2
`define PDC_CTRL_RST 2'h0
`define PDC_NPINS 21
`define PDC_LATCH_RST 21'h1FFFFF
`define PDC_DIR_RST 21'h000000
`define PDC_FSEL_RST 9'h000
`define PDC_OD_MASK 21'h03FC00
`define PDC_PIN_D0 0
`define PDC_PIN_D4 4
`define PDC_PIN_SCK 6
`define PDC_PIN_SI 7
`define PDC_PIN_SO 8
`define PDC_PIN_TOC 9
`define PDC_PIN_R0 6
`define PDC_PIN_R3 18
`define PDC_RESP_OKAY 2'h0
`define PDC_RESP_SLVERR 2'h2
`endif

// ---- pkg/pdc_pkg.sv ----
// types for the port pin drive and pull-up controller
// assumes pdc_params.svh is on the include path
`include "pdc_params.svh"
`default_nettype none
package pdc_pkg;
    // port instruction codes carried by the command register
    typedef enum logic [2:0] {
        pdc_op_none = 3'h0,
        pdc_op_set_d_bit = 3'h1,
        pdc_op_test_d_bit = 3'h3,
        pdc_op_clear_d_bit = 3'h2,
        pdc_op_load_port_to_acc = 3'h6,
        pdc_op_store_acc_to_port = 3'h7
    } pdc_op_e;
    // bus channel states
    typedef enum logic [1:0] {
        pdc_bus_idle = 2'h0,
        pdc_bus_resp = 2'h1
    } pdc_bus_e;
    // drive of all pins: level, output enable, pull-up on
    typedef struct packed {
        logic [`PDC_NPINS-1:0] lvl;
        logic [`PDC_NPINS-1:0] oe;
        logic [`PDC_NPINS-1:0] pu;
    } pdc_pin_drv_s;
    // outputs that on-chip peripherals offer to shared pins
    typedef struct packed {
        logic sck_lvl;
        logic sck_oe;
        logic so_lvl;
        logic toc_lvl;
    } pdc_periph_s;
endpackage : pdc_pkg
`default_nettype wire

// ---- src/pdc_top.sv ----
// port pin drive and pull-up controller with an AXI4-Lite register slave
// assumes pin levels and peripheral outputs are synchronous to mclk_in
`include "pdc_params.svh"
`default_nettype none
module pdc_top #(
    parameter int NPINS = `PDC_NPINS
) (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic stop_mode_in,
    input wire logic [NPINS-1:0] pin_lvl_in,
    input wire pdc_pkg::pdc_periph_s periph_in,
    output pdc_pkg::pdc_pin_drv_s pin_drv_out,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [11:0] s_axi_awaddr_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    output logic [1:0] s_axi_bresp_out,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    input wire logic [11:0] s_axi_araddr_in,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out
);
    import pdc_pkg::*;

    // ---------------------------------------------------------------
    // decoding shared by the write and read paths
    // ---------------------------------------------------------------
    function automatic logic addr_known(input logic [11:0] a);
        addr_known = (a == `PDC_ADDR_CTRL) || (a == `PDC_ADDR_DDIR) || (a == `PDC_ADDR_RDIR)
            || (a == `PDC_ADDR_FSEL) || (a == `PDC_ADDR_CMD) || (a == `PDC_ADDR_ACC);
    endfunction : addr_known

    // merge write data into a word under the byte strobes
    function automatic logic [31:0] strobe_merge(input logic [31:0] old, input logic [31:0] nw,
                                                 input logic [3:0] strb);
        logic [31:0] r;
        for (int b = 0; b < 4; b++)
        begin
            r[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
        end
        strobe_merge = r;
    endfunction : strobe_merge

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [1:0] ctrl_q, ctrl_d;
    logic [NPINS-1:0] latch_q, latch_d;
    logic [NPINS-1:0] dir_q, dir_d;
    logic [8:0] fsel_q, fsel_d;
    logic [3:0] acc_q, acc_d;
    pdc_bus_e wst_q, wst_d;
    pdc_bus_e rst_q, rst_d;
    logic aw_have_q, aw_have_d;
    logic w_have_q, w_have_d;
    logic [11:0] waddr_q, waddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic awready_q, awready_d;
    logic wready_q, wready_d;
    logic [1:0] bresp_q, bresp_d;
    logic arready_q, arready_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    pdc_pin_drv_s drv_q, drv_d;
    logic do_wr;
    logic [31:0] wmerged;
    pdc_op_e cmd_op;
    logic [3:0] cmd_idx;
    logic [3:0] cmd_dat;
    logic [NPINS-1:0] own_v, pov_v, plv_v;
    logic [NPINS-1:0] lvl_d, oe_d, pu_d;
    logic [31:0] rd_word;

    assign do_wr = aw_have_q && w_have_q && (wst_q == pdc_bus_idle);
    assign wmerged = strobe_merge(32'h00000000, wdata_q, wstrb_q);
    assign cmd_op = pdc_op_e'(wmerged[2:0]);
    assign cmd_idx = wmerged[7:4];
    assign cmd_dat = wmerged[11:8];

    // ---------------------------------------------------------------
    // write channel: address and data taken in either order
    // ---------------------------------------------------------------
    always_comb
    begin
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        waddr_d = waddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        wst_d = wst_q;
        bresp_d = bresp_q;
        if (s_axi_awvalid_in && awready_q)
        begin
            aw_have_d = 1'b1;
            waddr_d = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && wready_q)
        begin
            w_have_d = 1'b1;
            wdata_d = s_axi_wdata_in;
            wstrb_d = s_axi_wstrb_in;
        end
        case (wst_q)
            pdc_bus_idle:
            begin
                if (do_wr)
                begin
                    aw_have_d = 1'b0;
                    w_have_d = 1'b0;
                    wst_d = pdc_bus_resp;
                    bresp_d = addr_known(waddr_q) ? `PDC_RESP_OKAY : `PDC_RESP_SLVERR;
                end
            end
            pdc_bus_resp: wst_d = s_axi_bready_in ? pdc_bus_idle : pdc_bus_resp;
            default: wst_d = pdc_bus_idle;
        endcase
        awready_d = !aw_have_d && (wst_d == pdc_bus_idle);
        wready_d = !w_have_d && (wst_d == pdc_bus_idle);
    end

    // ---------------------------------------------------------------
    // control registers and the port instruction engine
    // ---------------------------------------------------------------
    always_comb
    begin
        ctrl_d = ctrl_q;
        latch_d = latch_q;
        dir_d = dir_q;
        fsel_d = fsel_q;
        acc_d = acc_q;
        if (do_wr)
        begin
            case (waddr_q)
                `PDC_ADDR_CTRL:
                begin
                    ctrl_d = wstrb_q[0] ? {wdata_q[`PDC_CTRL_PU_BIT], wdata_q[`PDC_CTRL_SOD_BIT]}
                        : ctrl_q;
                end
                `PDC_ADDR_DDIR: dir_d[5:0] = wmerged[5:0] | (dir_q[5:0] & ~{6{wstrb_q[0]}});
                `PDC_ADDR_RDIR:
                begin
                    dir_d[NPINS-1:6] = 15'(strobe_merge({17'h00000, dir_q[NPINS-1:6]}, wdata_q, wstrb_q));
                end
                `PDC_ADDR_FSEL: fsel_d = 9'(strobe_merge({23'h000000, fsel_q}, wdata_q, wstrb_q));
                `PDC_ADDR_CMD:
                begin
                    // latches are reached only through these instructions
                    case (cmd_op)
                        pdc_op_set_d_bit: latch_d[cmd_idx] = (cmd_idx < 4'h6) ? 1'b1 : latch_q[cmd_idx];
                        pdc_op_clear_d_bit: latch_d[cmd_idx] = (cmd_idx < 4'h6) ? 1'b0 : latch_q[cmd_idx];
                        pdc_op_test_d_bit: acc_d = (cmd_idx < 4'h6) ? {3'h0, pin_lvl_in[cmd_idx]} : 4'h0;
                        pdc_op_load_port_to_acc:
                            case (cmd_idx)
                                4'h0: acc_d = pin_lvl_in[9:6];
                                4'h1: acc_d = pin_lvl_in[13:10];
                                4'h2: acc_d = pin_lvl_in[17:14];
                                4'h3: acc_d = {pin_lvl_in[20:18], 1'b0};
                                default: acc_d = 4'h0;
                            endcase
                        pdc_op_store_acc_to_port:
                        begin
                            acc_d = cmd_dat;
                            case (cmd_idx)
                                4'h0: latch_d[9:6] = cmd_dat;
                                4'h1: latch_d[13:10] = cmd_dat;
                                4'h2: latch_d[17:14] = cmd_dat;
                                4'h3: latch_d[20:18] = cmd_dat[3:1];
                                default: latch_d = latch_q;
                            endcase
                        end
                        default: acc_d = acc_q;
                    endcase
                end
                default: acc_d = acc_q;
            endcase
        end
        if (stop_mode_in)
        begin
            ctrl_d = `PDC_CTRL_RST;
            latch_d = `PDC_LATCH_RST;
            dir_d = `PDC_DIR_RST;
            fsel_d = `PDC_FSEL_RST;
        end
    end

    // ---------------------------------------------------------------
    // read channel
    // ---------------------------------------------------------------
    always_comb
    begin
        case (s_axi_araddr_in)
            `PDC_ADDR_DDIR: rd_word = {26'h0000000, dir_q[5:0]};
            `PDC_ADDR_RDIR: rd_word = {17'h00000, dir_q[NPINS-1:6]};
            `PDC_ADDR_FSEL: rd_word = {23'h000000, fsel_q};
            `PDC_ADDR_ACC: rd_word = {28'h0000000, acc_q};
            default: rd_word = 32'h00000000; // write-only words read as zero
        endcase
    end

    always_comb
    begin
        rst_d = rst_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        case (rst_q)
            pdc_bus_idle:
            begin
                if (s_axi_arvalid_in && arready_q)
                begin
                    rst_d = pdc_bus_resp;
                    rdata_d = rd_word;
                    rresp_d = addr_known(s_axi_araddr_in) ? `PDC_RESP_OKAY : `PDC_RESP_SLVERR;
                end
            end
            pdc_bus_resp: rst_d = s_axi_rready_in ? pdc_bus_idle : pdc_bus_resp;
            default: rst_d = pdc_bus_idle;
        endcase
        // ready whenever idle, so a valid held through reset cannot lock the channel
        arready_d = (rst_d == pdc_bus_idle);
    end

    // ---------------------------------------------------------------
    // pin drive
    // ---------------------------------------------------------------
    // peripheral claims on shared pins
    always_comb
    begin
        own_v = '0;
        pov_v = '0;
        plv_v = '0;
        own_v[`PDC_PIN_SCK] = fsel_q[0];
        pov_v[`PDC_PIN_SCK] = periph_in.sck_oe;
        plv_v[`PDC_PIN_SCK] = periph_in.sck_lvl;
        own_v[`PDC_PIN_SI] = fsel_q[1];
        own_v[`PDC_PIN_SO] = fsel_q[2];
        pov_v[`PDC_PIN_SO] = 1'b1;
        plv_v[`PDC_PIN_SO] = periph_in.so_lvl;
        own_v[`PDC_PIN_TOC] = fsel_q[3];
        pov_v[`PDC_PIN_TOC] = 1'b1;
        plv_v[`PDC_PIN_TOC] = periph_in.toc_lvl;
        own_v[`PDC_PIN_D0] = fsel_q[4];
        own_v[`PDC_PIN_D4] = fsel_q[5];
        own_v[20:18] = fsel_q[8:6];
    end

    for (genvar i = 0; i < NPINS; i++)
    begin : g_pin
        localparam logic OD = 1'(`PDC_OD_MASK >> i);
        logic od_now;
        logic raw_oe;
        logic raw_lvl;
        // serial-out pin turns open-drain when selected
        assign od_now = OD || ((i == `PDC_PIN_SO) && ctrl_q[0]);
        assign raw_oe = own_v[i] ? pov_v[i] : dir_q[i];
        assign raw_lvl = own_v[i] ? plv_v[i] : latch_q[i];
        // open drain: drive only a low, float a high
        assign oe_d[i] = !stop_mode_in && raw_oe && !(od_now && raw_lvl);
        assign lvl_d[i] = od_now ? 1'b0 : raw_lvl;
        assign pu_d[i] = !OD && !stop_mode_in && ctrl_q[1] && latch_q[i];
    end

    assign drv_d = '{lvl: lvl_d, oe: oe_d, pu: pu_d};

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            ctrl_q <= `PDC_CTRL_RST;
            latch_q <= `PDC_LATCH_RST;
            dir_q <= `PDC_DIR_RST;
            fsel_q <= `PDC_FSEL_RST;
            acc_q <= 4'h0;
            wst_q <= pdc_bus_idle;
            rst_q <= pdc_bus_idle;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            waddr_q <= 12'h000;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bresp_q <= 2'h0;
            arready_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= 2'h0;
            drv_q <= '0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            latch_q <= latch_d;
            dir_q <= dir_d;
            fsel_q <= fsel_d;
            acc_q <= acc_d;
            wst_q <= wst_d;
            rst_q <= rst_d;
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            waddr_q <= waddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            drv_q <= drv_d;
        end
    end

    // outputs straight from flops
    assign pin_drv_out = drv_q;
    assign s_axi_awready_out = awready_q;
    assign s_axi_wready_out = wready_q;
    assign s_axi_bvalid_out = wst_q[0]; // only the answer state has bit 0 set
    assign s_axi_bresp_out = bresp_q;
    assign s_axi_arready_out = arready_q;
    assign s_axi_rvalid_out = rst_q[0]; // only the answer state has bit 0 set
    assign s_axi_rdata_out = rdata_q;
    assign s_axi_rresp_out = rresp_q;
endmodule : pdc_top
`default_nettype wire

// ---- sim/pdc_top_props.sv ----
// assertion checker for the pin drive controller, bound onto pdc_top
// assumes one clock domain and the port names of pdc_top
`include "pdc_params.svh"
`default_nettype none
module pdc_top_props
    import pdc_pkg::*;
#(
    parameter int NPINS = `PDC_NPINS
) (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic stop_mode_in,
    input wire pdc_pkg::pdc_pin_drv_s pin_drv_out,
    input wire logic s_axi_awvalid_in,
    input wire logic s_axi_awready_out,
    input wire logic s_axi_wvalid_in,
    input wire logic s_axi_wready_out,
    input wire logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [1:0] s_axi_bresp_out,
    input wire logic s_axi_arvalid_in,
    input wire logic s_axi_arready_out,
    input wire logic [11:0] s_axi_araddr_in,
    input wire logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic [1:0] s_axi_rresp_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    logic [NPINS-1:0] od_m;
    logic [NPINS-1:0] plain_m;
    logic ar_take;
    logic w_take;
    // open-drain pins and plain d pins without a shared function
    assign od_m = `PDC_OD_MASK;
    assign plain_m = 21'h00002E;
    assign ar_take = s_axi_arvalid_in & s_axi_arready_out;
    assign w_take = s_axi_awvalid_in & s_axi_awready_out & s_axi_wvalid_in & s_axi_wready_out;
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (sys_rst_in);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    property p_od_never_high;
        (pin_drv_out.oe & pin_drv_out.lvl & od_m) == '0;
    endproperty
    a_od_never_high: assert property (p_od_never_high)
        else $error("open-drain pin driven high");
    property p_od_no_pullup;
        (pin_drv_out.pu & od_m) == '0;
    endproperty
    a_od_no_pullup: assert property (p_od_no_pullup)
        else $error("pull-up on open-drain pin");
    property p_pu_only_high;
        (pin_drv_out.pu & pin_drv_out.oe & ~pin_drv_out.lvl & plain_m) == '0;
    endproperty
    a_pu_only_high: assert property (p_pu_only_high)
        else $error("pull-up on a pin driven low");
    property p_stop_float;
        stop_mode_in |=> (pin_drv_out.oe == '0) && (pin_drv_out.pu == '0);
    endproperty
    a_stop_float: assert property (p_stop_float)
        else $error("pins still active after stop");
    property p_rst_quiet;
        $fell(sys_rst_in) |-> (pin_drv_out.oe == '0) ##1 (pin_drv_out.pu == '0);
    endproperty
    a_rst_quiet: assert property (p_rst_quiet)
        else $error("pins active after reset");
    property p_b_answer;
        w_take |-> ##[1:2] s_axi_bvalid_out;
    endproperty
    a_b_answer: assert property (p_b_answer)
        else $error("write response missing");
    property p_b_hold;
        s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out);
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped");
    property p_r_answer;
        ar_take |=> s_axi_rvalid_out;
    endproperty
    a_r_answer: assert property (p_r_answer)
        else $error("read data missing");
    property p_r_hold;
        s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read data dropped");
    property p_ctrl_reads_zero;
        ar_take && s_axi_araddr_in == `PDC_ADDR_CTRL |=> s_axi_rdata_out == 32'h0 && s_axi_rresp_out == 2'h0;
    endproperty
    a_ctrl_reads_zero: assert property (p_ctrl_reads_zero)
        else $error("write-only register read back");
    property p_unmapped_err;
        ar_take && s_axi_araddr_in == 12'h100 |=> s_axi_rresp_out == `PDC_RESP_SLVERR;
    endproperty
    a_unmapped_err: assert property (p_unmapped_err)
        else $error("unmapped read not refused");
endmodule : pdc_top_props
bind pdc_top pdc_top_props #(.NPINS(NPINS)) chk_u (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
    .stop_mode_in(stop_mode_in), .pin_drv_out(pin_drv_out), .s_axi_awvalid_in(s_axi_awvalid_in),
    .s_axi_awready_out(s_axi_awready_out), .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
    .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in), .s_axi_bresp_out(s_axi_bresp_out),
    .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out), .s_axi_araddr_in(s_axi_araddr_in),
    .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in), .s_axi_rdata_out(s_axi_rdata_out),
    .s_axi_rresp_out(s_axi_rresp_out));
`default_nettype wire

// ---- sim/pdc_board_model.sv ----
// board model: returns the pin levels that the controller samples
// assumes registered pin drive on mclk_in; open-drain pins have board pull-ups
`include "pdc_params.svh"
`default_nettype none
module pdc_board_model
    import pdc_pkg::*;
(
    input wire logic mclk_in,
    input wire pdc_pkg::pdc_pin_drv_s pin_drv_in,
    output logic [`PDC_NPINS-1:0] pin_lvl_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [`PDC_NPINS-1:0] flt_q = '0;
    logic [`PDC_NPINS-1:0] od_m;
    assign od_m = `PDC_OD_MASK;
    // a floating cmos pin shows a pattern that changes every cycle
    always_ff @(posedge mclk_in)
        flt_q <= ~flt_q;
    // driver wins, then internal or board pull-up, else floating
    always_comb
        for (int i = 0; i < `PDC_NPINS; i++)
            pin_lvl_out[i] = pin_drv_in.oe[i] ? pin_drv_in.lvl[i] : (pin_drv_in.pu[i] | od_m[i]) ? 1'b1 : flt_q[i];
endmodule : pdc_board_model
`default_nettype wire

// ---- sim/tb_top.sv ----
// testbench for the pin drive controller: bus tasks and directed tests
// assumes pdc_top, the board model and the bound checker
`include "pdc_params.svh"
`default_nettype none
module tb_top;
    import pdc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [20:0] CMOS_M = 21'h1C03FF;
    logic mclk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic stop_mode_in = 1'b0;
    logic [20:0] pin_lvl;
    pdc_periph_s periph = '0;
    pdc_pin_drv_s drv;
    logic awv = 0, awr, wv = 0, wrdy, bv, br = 0, arv = 0, arr, rv, rr = 0;
    logic [11:0] awa = '0, ara = '0;
    logic [31:0] wd = '0, rdat, rd;
    logic [1:0] bresp, rresp, rs;
    int bad_count = 0;
    int num_checks = 0;
    always #12.5 mclk_in = ~mclk_in;
    pdc_board_model brd_u (.mclk_in(mclk_in), .pin_drv_in(drv), .pin_lvl_out(pin_lvl));
    pdc_top #(.NPINS(21)) dut_u (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .stop_mode_in(stop_mode_in),
        .pin_lvl_in(pin_lvl), .periph_in(periph), .pin_drv_out(drv), .s_axi_awvalid_in(awv),
        .s_axi_awready_out(awr), .s_axi_awaddr_in(awa), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrdy),
        .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF), .s_axi_bvalid_out(bv), .s_axi_bready_in(br),
        .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_araddr_in(ara),
        .s_axi_rvalid_out(rv), .s_axi_rready_in(rr), .s_axi_rdata_out(rdat), .s_axi_rresp_out(rresp));
    // ----------------------------------------------------------------
    // checking and closing
    // ----------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic pchk(input logic [20:0] seen, input logic [20:0] exp);
        chk({11'h0, seen}, {11'h0, exp});
    endtask : pchk
    task automatic tmo(input int n);
        if (n >= 100)
        begin
            chk(n, 0);
            finish_test();
        end
    endtask : tmo
    task automatic settle();
        repeat (3) @(posedge mclk_in);
    endtask : settle
    // ----------------------------------------------------------------
    // bus tasks
    // ----------------------------------------------------------------
    task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
        int n;
        logic ad;
        logic dd;
        n = 0;
        ad = 0;
        dd = 0;
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        while (!(ad && dd) && n < 100)
        begin
            @(posedge mclk_in);
            n++;
            ad = ad | awr;
            dd = dd | wrdy;
            awv <= !ad;
            wv <= !dd;
        end
        tmo(n);
        br <= 1'b1;
        n = 0;
        do @(posedge mclk_in);
        while (!bv && ++n < 100);
        tmo(n);
        rs = bresp;
        br <= 1'b0;
    endtask : bus_wr
    task automatic bus_rd(input logic [11:0] a);
        int n;
        n = 0;
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do
        begin
            @(posedge mclk_in);
            if (arr)
                arv <= 1'b0;
        end
        while (!rv && ++n < 100);
        tmo(n);
        rd = rdat;
        rs = rresp;
        rr <= 1'b0;
    endtask : bus_rd
    task automatic cmd(input logic [2:0] op, input logic [3:0] idx, input logic [3:0] d);
        bus_wr(`PDC_ADDR_CMD, {20'h0, d, idx, 1'b0, op});
    endtask : cmd
    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        // reset state and refused accesses
        pchk(drv.oe, 21'h0);
        pchk(drv.pu, 21'h0);
        bus_rd(`PDC_ADDR_CTRL);
        chk(rd, 32'h0);
        bus_rd(12'h100);
        chk({30'h0, rs}, {30'h0, `PDC_RESP_SLVERR});
        bus_wr(12'h100, 32'hF);
        chk({30'h0, rs}, {30'h0, `PDC_RESP_SLVERR});
        $display("test reset done");
        // pull-up follows enable and latches only
        bus_wr(`PDC_ADDR_CTRL, 32'h8);
        settle();
        pchk(drv.pu, CMOS_M);
        bus_wr(`PDC_ADDR_FSEL, 32'h1FF);
        settle();
        pchk(drv.pu, CMOS_M);
        cmd(3'h2, 4'h1, 4'h0);
        settle();
        pchk(drv.pu, CMOS_M & ~21'h2);
        bus_wr(`PDC_ADDR_CTRL, 32'h0);
        settle();
        pchk(drv.pu, 21'h0);
        bus_wr(`PDC_ADDR_FSEL, 32'h0);
        $display("test pullup done");
        // d port drive and single-bit access
        bus_wr(`PDC_ADDR_DDIR, 32'h3F);
        settle();
        pchk(drv.oe, 21'h3F);
        pchk(drv.lvl & 21'h3F, 21'h3D);
        cmd(3'h1, 4'h1, 4'h0);
        cmd(3'h3, 4'h1, 4'h0);
        bus_rd(`PDC_ADDR_ACC);
        chk(rd & 32'h1, 32'h1);
        cmd(3'h2, 4'h3, 4'h0);
        cmd(3'h3, 4'h3, 4'h0);
        bus_rd(`PDC_ADDR_ACC);
        chk(rd & 32'h1, 32'h0);
        bus_wr(`PDC_ADDR_DDIR, 32'h0);
        settle();
        pchk(drv.oe, 21'h0);
        $display("test d port done");
        // r ports: open drain, nibble transfer, analog select
        bus_wr(`PDC_ADDR_RDIR, 32'h7FF0);
        cmd(3'h7, 4'h1, 4'h5);
        settle();
        pchk(drv.oe & `PDC_OD_MASK, 21'h02800);
        pchk(drv.lvl & `PDC_OD_MASK, 21'h0);
        pchk(drv.oe & 21'h1C0000, 21'h1C0000);
        cmd(3'h6, 4'h2, 4'h0);
        bus_rd(`PDC_ADDR_ACC);
        chk(rd & 32'hF, 32'hF);
        cmd(3'h6, 4'h1, 4'h0);
        bus_rd(`PDC_ADDR_ACC);
        chk(rd & 32'hF, 32'h5);
        bus_wr(`PDC_ADDR_FSEL, 32'h1C0);
        settle();
        pchk(drv.oe & 21'h1C0000, 21'h0);
        bus_wr(`PDC_ADDR_FSEL, 32'h0);
        bus_wr(`PDC_ADDR_RDIR, 32'h0);
        settle();
        pchk(drv.oe, 21'h0);
        $display("test r port done");
        // serial-out pin drive select and peripheral override
        bus_wr(`PDC_ADDR_RDIR, 32'h4);
        settle();
        pchk(drv.oe & drv.lvl & 21'h100, 21'h100);
        bus_wr(`PDC_ADDR_CTRL, 32'h7);
        settle();
        pchk(drv.oe & 21'h100, 21'h0);
        cmd(3'h7, 4'h0, 4'h0);
        settle();
        pchk(drv.oe & ~drv.lvl & 21'h100, 21'h100);
        periph.so_lvl <= 1'b1;
        bus_wr(`PDC_ADDR_FSEL, 32'h4);
        settle();
        pchk(drv.oe & 21'h100, 21'h0);
        bus_wr(`PDC_ADDR_CTRL, 32'h0);
        settle();
        pchk(drv.oe & drv.lvl & 21'h100, 21'h100);
        $display("test serial out done");
        // stop mode clears control, direction and select and forces latches high
        bus_wr(`PDC_ADDR_CTRL, 32'h8);
        stop_mode_in <= 1'b1;
        @(posedge mclk_in);
        stop_mode_in <= 1'b0;
        settle();
        pchk(drv.oe, 21'h0);
        pchk(drv.pu, 21'h0);
        bus_wr(`PDC_ADDR_CTRL, 32'h8);
        settle();
        pchk(drv.pu, CMOS_M);
        $display("test stop done");
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
